// file: logic/acwd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "acwd_defines.svh"
module acwd_decoder #(
	parameter int CONV_DELAY_CYC = `ACWD_CONV_DELAY_CYC
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic addr_pin,
	input wire logic sclk_pin,
	input wire logic sdata_in_pin,
	input wire logic transmit_frame_sync_n_pin,
	input wire logic read_frame_sync_n_pin,
	input wire logic result_bit,
	input wire logic conv_done,
	output logic sdata_out,
	output logic sdata_oe,
	output logic conv_start,
	output logic convert_pending,
	output acwd_pkg::acwd_pwr_t power_state,
	output logic [2:0] input_pos,
	output logic [2:0] input_neg,
	output acwd_pkg::acwd_neg_t neg_kind,
	output logic input_valid,
	output logic test_half_ref,
	output logic test_full_ref,
	output logic external_reference_select,
	output logic int_ref_power_down,
	output logic [9:0] active_word
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers. Every pin is foreign to mclk, so each one passes two
// flops before any logic looks at it.

localparam int NSYNC = 5;
logic [NSYNC-1:0] pins;
logic [NSYNC-1:0] sync1_ff;
logic [NSYNC-1:0] sync2_ff;
logic [NSYNC-1:0] sync3_ff;

assign pins = {addr_pin, sclk_pin, sdata_in_pin,
	transmit_frame_sync_n_pin, read_frame_sync_n_pin};

genvar gi;
generate
	for (gi = 0; gi < NSYNC; gi++) begin : g_sync
		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				sync1_ff[gi] <= 1'b1;
				sync2_ff[gi] <= 1'b1;
				sync3_ff[gi] <= 1'b1;
			end else if (clk_en) begin
				sync1_ff[gi] <= pins[gi];
				sync2_ff[gi] <= sync1_ff[gi];
				sync3_ff[gi] <= sync2_ff[gi];
			end
		end
	end
endgenerate

logic addr_s;
logic sclk_fall;
logic sdata_s;
logic tfs_n_s;
logic tfs_fall;
logic rfs_n_s;

assign addr_s = sync2_ff[4];
assign sclk_fall = sync3_ff[3] & ~sync2_ff[3];
assign sdata_s = sync2_ff[2];
assign tfs_n_s = sync2_ff[1];
assign tfs_fall = sync3_ff[1] & ~sync2_ff[1];
assign rfs_n_s = sync2_ff[0];

////////////////////////////////////////////////////////////////////////////////
// Serial word receiver. A frame that ends early is dropped whole, so a
// partly shifted word can never reach the configuration.

logic in_frame_ff;
logic [3:0] bit_cnt_ff;
logic [9:0] shift_ff;
logic word_ready;
logic [9:0] word_rx;

assign word_rx = {shift_ff[8:0], sdata_s};
assign word_ready = in_frame_ff & sclk_fall & !tfs_n_s
	& (bit_cnt_ff == `ACWD_BITS_LAST);

always_ff @(posedge mclk or negedge reset_n) begin
	if (!reset_n) begin
		in_frame_ff <= 1'b0;
		bit_cnt_ff <= 4'h0;
		shift_ff <= `ACWD_WORD_RST;
	end else if (clk_en) begin
		if (tfs_fall) begin
			in_frame_ff <= 1'b1;
			bit_cnt_ff <= 4'h0;
		end else if (tfs_n_s || word_ready) begin
			in_frame_ff <= 1'b0;
		end else if (in_frame_ff && sclk_fall) begin
			shift_ff <= word_rx;
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control word store. The receiver runs independently of the read path, so
// a write lands even while a result is being shifted out.

logic word_match;
logic [9:0] ctl_ff;
logic selected_ff;

assign word_match = word_ready
	& (word_rx[`ACWD_BIT_ADDR] == addr_s);

always_ff @(posedge mclk or negedge reset_n) begin
	if (!reset_n) begin
		ctl_ff <= `ACWD_WORD_RST;
	end else if (clk_en) begin
		if (word_match) begin
			ctl_ff <= word_rx;
		end else if (conv_done) begin
			ctl_ff[`ACWD_BIT_CONV] <= 1'b0;
		end
	end
end

// A mismatched word on the shared bus deselects this device.
always_ff @(posedge mclk or negedge reset_n) begin
	if (!reset_n) begin
		selected_ff <= 1'b0;
	end else if (clk_en && word_ready) begin
		selected_ff <= word_match;
	end
end

assign active_word = ctl_ff;
assign convert_pending = ctl_ff[`ACWD_BIT_CONV];

////////////////////////////////////////////////////////////////////////////////
// Serial read output. The pin stays released unless this device took the
// most recent address-matched word and a read frame is open.

logic sdata_ff;

always_ff @(posedge mclk or negedge reset_n) begin
	if (!reset_n) begin
		sdata_ff <= 1'b0;
	end else if (clk_en) begin
		sdata_ff <= result_bit;
	end
end

assign sdata_out = sdata_ff;
assign sdata_oe = selected_ff & !rfs_n_s;

////////////////////////////////////////////////////////////////////////////////
// Software convert start. The delay gives the input time to settle when
// the same word also switches channel.

localparam int DW = $clog2(CONV_DELAY_CYC + 1);
logic [DW-1:0] delay_ff;
logic delay_run_ff;
logic start_ff;

always_ff @(posedge mclk or negedge reset_n) begin
	if (!reset_n) begin
		delay_ff <= '0;
		delay_run_ff <= 1'b0;
		start_ff <= 1'b0;
	end else if (clk_en) begin
		start_ff <= 1'b0;
		if (word_match && word_rx[`ACWD_BIT_CONV]) begin
			delay_run_ff <= 1'b1;
			delay_ff <= DW'(CONV_DELAY_CYC - 1);
		end else if (delay_run_ff) begin
			if (delay_ff == '0) begin
				delay_run_ff <= 1'b0;
				start_ff <= 1'b1;
			end else begin
				delay_ff <= delay_ff - DW'(1);
			end
		end
	end
end

assign conv_start = start_ff;

////////////////////////////////////////////////////////////////////////////////
// Power state. In codes 01 and 10 a conversion start wakes the converter;
// those two automatic codes then pick the sleep depth once it completes.

acwd_pkg::acwd_pwr_t pwr_ff;
acwd_pkg::acwd_pwr_t nxt_pwr;
logic [1:0] pfield;

assign pfield = ctl_ff[`ACWD_BIT_PWR_HI:`ACWD_BIT_PWR_LO];

always_comb begin
	nxt_pwr = pwr_ff;
	case (pfield)
		`ACWD_PWR_FULL_NOW: nxt_pwr = acwd_pkg::ACWD_PWR_FULL;
		`ACWD_PWR_UP: nxt_pwr = acwd_pkg::ACWD_PWR_ON;
		`ACWD_PWR_PART_END: begin
			if (conv_done) begin
				nxt_pwr = acwd_pkg::ACWD_PWR_PARTIAL;
			end else if (start_ff) begin
				nxt_pwr = acwd_pkg::ACWD_PWR_ON;
			end
		end
		default: begin
			if (conv_done) begin
				nxt_pwr = acwd_pkg::ACWD_PWR_FULL;
			end else if (start_ff) begin
				nxt_pwr = acwd_pkg::ACWD_PWR_ON;
			end
		end
	endcase
end

always_ff @(posedge mclk or negedge reset_n) begin
	if (!reset_n) begin
		pwr_ff <= acwd_pkg::ACWD_PWR_FULL;
	end else if (clk_en) begin
		pwr_ff <= nxt_pwr;
	end
end

assign power_state = pwr_ff;

////////////////////////////////////////////////////////////////////////////////
// Reference select.

assign external_reference_select = ctl_ff[`ACWD_BIT_EXTERNAL_REFERENCE_SELECT];
assign int_ref_power_down = ctl_ff[`ACWD_BIT_EXTERNAL_REFERENCE_SELECT];

////////////////////////////////////////////////////////////////////////////////
// Input multiplexer decode. Indices are zero based: 0 is input one.

logic [2:0] ch;
logic pair_mode;
logic common_sel;

assign ch = ctl_ff[`ACWD_BIT_CH_HI:`ACWD_BIT_CH_LO];
assign pair_mode = ctl_ff[`ACWD_BIT_PAIR];
assign common_sel = ctl_ff[`ACWD_BIT_COMMON];

always_comb begin
	input_pos = 3'h0;
	input_neg = 3'h0;
	neg_kind = acwd_pkg::ACWD_REF_NONE;
	input_valid = 1'b0;
	test_half_ref = 1'b0;
	test_full_ref = 1'b0;
	if (pair_mode) begin
		if (!ch[2]) begin
			input_pos = {ch[1:0], 1'b0};
			input_neg = {ch[1:0], 1'b1};
			neg_kind = acwd_pkg::ACWD_REF_PAIR;
			input_valid = 1'b1;
		end else if (ch == `ACWD_CH_TEST_HALF) begin
			test_half_ref = 1'b1;
		end else if (ch == `ACWD_CH_TEST_FULL) begin
			test_full_ref = 1'b1;
		end
		// Codes 110 and 111 leave everything deselected.
	end else if (common_sel) begin
		if (ch <= `ACWD_CH_LAST_COMMON) begin
			input_pos = ch;
			input_neg = `ACWD_IN_COMMON;
			neg_kind = acwd_pkg::ACWD_REF_COMMON;
			input_valid = 1'b1;
		end
	end else begin
		input_pos = ch;
		neg_kind = acwd_pkg::ACWD_REF_GROUND;
		input_valid = 1'b1;
	end
end

endmodule : acwd_decoder
`default_nettype wire

// file: logic/acwd_defines.svh
// Behaviour
// - Word bit 9 must match the address pin, else whole word discarded.
// - Only the last address-matched device drives serial data on next read.
// - Stored package address bit is 0 after power-up.
// - Power field 00 full down, 01/10 down at end, 11 power up.
// - Codes 00 and 11 override the automatic end-of-conversion decision.
// - Codes 01 and 10 enter partial or full down after each conversion.
// - Common-input select applies only while pair mode is 0.
// - Common select 0 gives eight ground inputs; 1 gives one-seven versus eight.
// - Pair mode forms pairs 1/2,3/4,5/6,7/8 for codes 000-011, odd positive.
// - Single-ended codes 000-111 select inputs one to eight ascending.
// - Common-referenced codes 000-110 select inputs one to seven versus eight.
// - Pair code 100 tests half reference, 101 tests full reference.
// - Convert bit set starts a conversion 400 ns after the write.
// - Stored convert bit clears when its conversion finishes.
// - External-reference bit selects reference pin and powers down internal one.
// - Word is framed by frame sync; capture starts on its falling edge.
// - All control bits are zero at power-up, so device starts powered down.
// - Configuration holds until next accepted word; writes allowed during reads.
`ifndef ACWD_DEFINES_SVH
`define ACWD_DEFINES_SVH
`define ACWD_WORD_W 10
`define ACWD_WORD_RST 10'h000
`define ACWD_BIT_ADDR 9
`define ACWD_BIT_PWR_HI 8
`define ACWD_BIT_PWR_LO 7
`define ACWD_BIT_COMMON 6
`define ACWD_BIT_PAIR 5
`define ACWD_BIT_CH_HI 4
`define ACWD_BIT_CH_LO 2
`define ACWD_BIT_CONV 1
`define ACWD_BIT_EXTERNAL_REFERENCE_SELECT 0
`define ACWD_PWR_FULL_NOW 2'h0
`define ACWD_PWR_PART_END 2'h1
`define ACWD_PWR_FULL_END 2'h2
`define ACWD_PWR_UP 2'h3
`define ACWD_CH_TEST_HALF 3'h4
`define ACWD_CH_TEST_FULL 3'h5
`define ACWD_CH_LAST_COMMON 3'h6
`define ACWD_IN_COMMON 3'h7
`define ACWD_BITS_LAST 4'h9
`define ACWD_MCLK_MHZ 250
`define ACWD_CONV_DELAY_NS 400
`define ACWD_CONV_DELAY_CYC \
	((`ACWD_CONV_DELAY_NS * `ACWD_MCLK_MHZ + 999) / 1000)
`endif

// file: logic/acwd_pkg.sv
`default_nettype none
package acwd_pkg;
	typedef enum logic [2:0] {
		ACWD_PWR_ON = 3'h1,
		ACWD_PWR_PARTIAL = 3'h2,
		ACWD_PWR_FULL = 3'h4
	} acwd_pwr_t;
	typedef enum logic [3:0] {
		ACWD_REF_GROUND = 4'h1,
		ACWD_REF_COMMON = 4'h2,
		ACWD_REF_PAIR = 4'h4,
		ACWD_REF_NONE = 4'h8
	} acwd_neg_t;
endpackage : acwd_pkg
`default_nettype wire

// file: dv/acwd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module acwd_host_model (
	input wire logic mclk,
	output logic sclk,
	output logic sdata,
	output logic tfs_n,
	output logic rfs_n
);
	initial begin
		sclk = 1'b1;
		sdata = 1'b0;
		tfs_n = 1'b1;
		rfs_n = 1'b1;
	end
	// Frame opens on falling frame sync; ten bits go out MSB first.
	task write_word(input logic [9:0] w, input int h);
		tfs_n = 1'b0;
		repeat (h) @(negedge mclk);
		for (int i = 9; i >= 0; i--) begin
			sdata = w[i];
			sclk = 1'b1;
			repeat (h) @(negedge mclk);
			sclk = 1'b0;
			if (i > 0) repeat (h) @(negedge mclk);
		end
	endtask : write_word
	task end_frame(input int h);
		repeat (h) @(negedge mclk);
		tfs_n = 1'b1;
		sclk = 1'b1;
		// A released line must not keep showing the last bit.
		sdata = ~sdata;
		repeat (h) @(negedge mclk);
	endtask : end_frame
	task set_read(input logic v);
		rfs_n = v;
	endtask : set_read
endmodule : acwd_host_model
`default_nettype wire

// file: dv/acwd_chk.sv
`timescale 1ns/1ns
`default_nettype none
module acwd_chk #(
	parameter int CONV_DELAY_CYC = 100
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic addr_pin,
	input wire logic read_frame_sync_n_pin,
	input wire logic conv_done,
	input wire logic sdata_oe,
	input wire logic conv_start,
	input wire logic convert_pending,
	input wire acwd_pkg::acwd_pwr_t power_state,
	input wire logic input_valid,
	input wire logic test_half_ref,
	input wire logic test_full_ref,
	input wire logic external_reference_select,
	input wire logic int_ref_power_down,
	input wire logic [9:0] active_word
);
	// The pending bit is sampled one edge after it loads, as is the pulse.
	localparam int D = CONV_DELAY_CYC;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	property p_addr;
		$changed(active_word) |-> active_word[9] == addr_pin;
	endproperty
	a_addr: assert property (p_addr) else $error("address");
	property p_read;
		sdata_oe |-> !$past(read_frame_sync_n_pin, 2);
	endproperty
	a_read: assert property (p_read) else $error("read drive");
	property p_pwr;
		$changed(active_word) && active_word[8] == active_word[7] |=>
			power_state[2] == !active_word[8];
	endproperty
	a_pwr: assert property (p_pwr) else $error("power");
	property p_conv;
		$rose(convert_pending) |-> ##D conv_start;
	endproperty
	a_conv: assert property (p_conv) else $error("start delay");
	property p_clr;
		conv_done |=> !convert_pending || $changed(active_word);
	endproperty
	a_clr: assert property (p_clr) else $error("pending");
	property p_ref;
		external_reference_select == active_word[0] &&
			int_ref_power_down == active_word[0];
	endproperty
	a_ref: assert property (p_ref) else $error("reference");
	property p_test;
		active_word[5] |-> test_half_ref == (active_word[4:2] == 3'h4) &&
			test_full_ref == (active_word[4:2] == 3'h5);
	endproperty
	a_test: assert property (p_test) else $error("self test");
	property p_resv;
		active_word[5] && active_word[4:3] == 2'h3 |-> !input_valid;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved");
	c_conv: cover property (conv_start);
	c_read: cover property (sdata_oe);
	c_test: cover property (test_full_ref);
endmodule : acwd_chk
bind acwd_decoder acwd_chk #(.CONV_DELAY_CYC(CONV_DELAY_CYC)) u_chk (
	.mclk(mclk), .reset_n(reset_n), .addr_pin(addr_pin),
	.read_frame_sync_n_pin(read_frame_sync_n_pin), .conv_done(conv_done),
	.sdata_oe(sdata_oe), .conv_start(conv_start),
	.convert_pending(convert_pending), .power_state(power_state),
	.input_valid(input_valid), .test_half_ref(test_half_ref),
	.test_full_ref(test_full_ref), .int_ref_power_down(int_ref_power_down),
	.external_reference_select(external_reference_select),
	.active_word(active_word));
`default_nettype wire

// file: dv/test_acwd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module test_acwd_decoder;
	// Short start delay keeps the run brief.
	localparam int CD = 4;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic res_bit = 1'b0;
	logic conv_done = 1'b0;
	logic cen = 1'b1;
	logic addr = 1'b1;
	logic sclk, sdat, tfs_n, rfs_n, sout, oe, cst, pend, valid, half, full;
	logic xref, iref;
	logic [2:0] pos, neg;
	logic [9:0] word;
	acwd_pkg::acwd_pwr_t pwr;
	acwd_pkg::acwd_neg_t kind;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	always #2 mclk = ~mclk;
	always @(negedge mclk) res_bit <= ~res_bit;
	acwd_host_model u_host (.mclk(mclk), .sclk(sclk), .sdata(sdat),
		.tfs_n(tfs_n), .rfs_n(rfs_n));
	acwd_decoder #(.CONV_DELAY_CYC(CD)) u_dut (.mclk(mclk), .reset_n(reset_n),
		.clk_en(cen), .addr_pin(addr), .sclk_pin(sclk), .sdata_in_pin(sdat),
		.transmit_frame_sync_n_pin(tfs_n), .read_frame_sync_n_pin(rfs_n),
		.result_bit(res_bit), .conv_done(conv_done), .sdata_out(sout),
		.sdata_oe(oe), .conv_start(cst), .convert_pending(pend),
		.power_state(pwr), .input_pos(pos), .input_neg(neg), .neg_kind(kind),
		.input_valid(valid), .test_half_ref(half), .test_full_ref(full),
		.external_reference_select(xref), .int_ref_power_down(iref),
		.active_word(word));
	task chk(input string s, input logic [9:0] seen, input logic [9:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	task wr(input logic [9:0] w);
		u_host.write_word(w, 3);
		u_host.end_frame(3);
	endtask : wr
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			error_cnt++;
			give_verdict();
		end
	end
	///////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge mclk);
		chk("word", word, 10'h000);
		chk("power", 10'(pwr), 10'(acwd_pkg::ACWD_PWR_FULL));
		reset_n = 1'b1;
		repeat (3) @(negedge mclk);
		wr(10'h1FF);
		chk("word", word, 10'h000);
		wr(10'h389);
		chk("word", word, 10'h389);
		chk("power", 10'(pwr), 10'(acwd_pkg::ACWD_PWR_ON));
		chk("ref", {8'h00, xref, iref}, 10'h003);
		for (int i = 0; i < 8; i++) begin
			wr(10'h380 | 10'(i << 2));
			chk("pos", {4'h0, pos, neg}, 10'(i * 8));
			chk("kind", 10'(kind), 10'(acwd_pkg::ACWD_REF_GROUND));
		end
		wr(10'h3D8);
		chk("pos", {4'h0, pos, neg}, 10'h037);
		chk("kind", 10'(kind), 10'(acwd_pkg::ACWD_REF_COMMON));
		// Code 111 in common mode has no input behind it.
		wr(10'h3DC);
		chk("valid", 10'(valid), 10'h000);
		// Common select set in pair mode must be ignored.
		for (int i = 0; i < 8; i++) begin
			wr(10'h3E0 | 10'(i << 2));
			if (i < 4) begin
				chk("pair", {4'h0, pos, neg}, 10'(i * 18 + 1));
				chk("kind", 10'(kind), 10'(acwd_pkg::ACWD_REF_PAIR));
			end
			n = (i == 4) ? 2 : ((i == 5) ? 1 : 0);
			chk("test", {8'h00, half, full}, 10'(n));
			if (i > 5) chk("valid", 10'(valid), 10'h000);
		end
		u_host.set_read(1'b0);
		repeat (3) @(negedge mclk);
		chk("oe", {8'h00, oe, sout}, {8'h00, 1'b1, res_bit});
		wr(10'h1E0);
		chk("oe", 10'(oe), 10'h000);
		chk("word", word, 10'h3FC);
		wr(10'h3FC);
		chk("oe", 10'(oe), 10'h001);
		u_host.set_read(1'b1);
		wr(10'h200);
		chk("power", 10'(pwr), 10'(acwd_pkg::ACWD_PWR_FULL));
		for (int k = 1; k < 3; k++) begin
			u_host.write_word(10'h202 | 10'(k << 7), 5);
			n = 0;
			while (word[8:7] !== 2'(k) && n < 99) begin
				@(negedge mclk);
				n++;
			end
			n = 0;
			while (cst !== 1'b1 && n < 99) begin
				@(negedge mclk);
				n++;
			end
			chk("delay", 10'(n), 10'(CD));
			u_host.end_frame(5);
			conv_done = 1'b1;
			@(negedge mclk);
			conv_done = 1'b0;
			@(negedge mclk);
			chk("pending", 10'(pend), 10'h000);
			chk("power", 10'(pwr), 10'(k * 2));
		end
		// A frozen clock enable must hold the stored word through a write.
		cen = 1'b0;
		wr(10'h3C0);
		chk("freeze", word, 10'h300);
		cen = 1'b1;
		// With the address pin low, only words with bit 9 clear are taken.
		addr = 1'b0;
		repeat (3) @(negedge mclk);
		wr(10'h3FC);
		chk("word", word, 10'h300);
		wr(10'h1E0);
		chk("word", word, 10'h1E0);
		chk("power", 10'(pwr), 10'(acwd_pkg::ACWD_PWR_ON));
		give_verdict();
	end
endmodule : test_acwd_decoder
`default_nettype wire
